// ### rtl/sync2.sv
/*
  Two-flop synchroniser bank for pin inputs.
  Assumes the single core clock and an active-low asynchronous reset.
*/
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ### rtl/wdt_pkg.sv
/*
  Shared constants and types for the I/O-read watchdog timer.
  Assumes a 25 MHz core clock and a 16-bit host I/O read port decode.
*/
`default_nettype none
package wdt_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [15:0] DISABLE_PORT_ADDR = 16'h0043;
  localparam logic [15:0] ENABLE_PORT_ADDR = 16'h0443;
  localparam logic [7:0] PORT_READ_DATA = 8'hFF;
  // Period choices in milliseconds, one per strap code
  localparam int unsigned PERIOD_MS_0 = 1000;
  localparam int unsigned PERIOD_MS_1 = 2000;
  localparam int unsigned PERIOD_MS_2 = 5000;
  localparam int unsigned PERIOD_MS_3 = 10000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
  localparam logic [15:0] TIMER_ZERO = 16'h0000;
  localparam logic [15:0] TIMER_ONE = 16'h0001;
  localparam int unsigned RESET_PULSE_CYCLES = 16;
  localparam logic [4:0] RESET_PULSE_LAST = 5'(RESET_PULSE_CYCLES - 1);
  localparam logic ACTION_RESET = 1'b0;
  localparam logic ACTION_NMI = 1'b1;
  typedef struct packed {
    logic action;
    logic [1:0] period;
  } straps_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_FIRE = 3'b100
  } wdt_state_t;
endpackage
`default_nettype wire

// ### rtl/wdt_top.sv
/*
  Watchdog timer driven only by host I/O reads of two ports.
  Assumes the host read strobe and address are synchronous to CORE_CLK;
  strap pins are asynchronous and are synchronised here.
*/
`default_nettype none
module wdt_top #(
  // Core cycles per period tick; the default gives a millisecond tick
  parameter int unsigned CYCLES_PER_TICK = wdt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Host I/O read port
  input wire logic IO_RD,
  input wire logic [15:0] IO_ADDR,
  output logic [7:0] IO_RDATA,
  output logic IO_RDATA_VALID,
  // Board straps
  input wire logic TIMEOUT_ACTION_STRAP,
  input wire logic [1:0] TIMEOUT_PERIOD_STRAPS,
  // Time-out actions and status
  output logic COLD_RESET,
  output logic NMI,
  output logic WDT_RUNNING
);
  localparam logic [14:0] tick_last = 15'(CYCLES_PER_TICK - 1);
  wdt_pkg::straps_t straps_raw;
  wdt_pkg::straps_t straps_sync;
  wdt_pkg::wdt_state_t state_ff;
  logic [14:0] tick_cnt_ff;
  logic tick_ff;
  logic [15:0] timer_ff;
  logic [15:0] reload_val;
  logic [4:0] pulse_cnt_ff;
  logic rd_enable;
  logic rd_disable;

  assign straps_raw = '{action: TIMEOUT_ACTION_STRAP, period: TIMEOUT_PERIOD_STRAPS};

  sync2 #(.W(3)) u_strap_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d(straps_raw),
    .q(straps_sync)
  );

  assign rd_enable = IO_RD && (IO_ADDR == wdt_pkg::ENABLE_PORT_ADDR);
  assign rd_disable = IO_RD && (IO_ADDR == wdt_pkg::DISABLE_PORT_ADDR);

  // Period read live from straps so a jumper change applies at the next reload
  always_comb begin
    unique case (straps_sync.period)
      2'h0: reload_val = 16'(wdt_pkg::PERIOD_MS_0);
      2'h1: reload_val = 16'(wdt_pkg::PERIOD_MS_1);
      2'h2: reload_val = 16'(wdt_pkg::PERIOD_MS_2);
      2'h3: reload_val = 16'(wdt_pkg::PERIOD_MS_3);
    endcase
  end

  // Millisecond tick enable
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == tick_last) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 15'h0001;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= wdt_pkg::ST_OFF;
      timer_ff <= wdt_pkg::TIMER_ZERO;
      pulse_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        wdt_pkg::ST_OFF: begin
          if (rd_enable) begin
            state_ff <= wdt_pkg::ST_RUN;
            timer_ff <= reload_val;
          end
        end
        wdt_pkg::ST_RUN: begin
          // Disable wins over a simultaneous tick; only one port can be read at once
          if (rd_disable) begin
            state_ff <= wdt_pkg::ST_OFF;
          end else if (rd_enable) begin
            timer_ff <= reload_val;
          end else if (tick_ff) begin
            if (timer_ff == wdt_pkg::TIMER_ONE) begin
              state_ff <= wdt_pkg::ST_FIRE;
              pulse_cnt_ff <= '0;
            end
            timer_ff <= timer_ff - wdt_pkg::TIMER_ONE;
          end
        end
        wdt_pkg::ST_FIRE: begin
          // Fixed-width pulse; the watchdog then stays off until re-enabled
          if (pulse_cnt_ff == wdt_pkg::RESET_PULSE_LAST) begin
            state_ff <= wdt_pkg::ST_OFF;
          end else begin
            pulse_cnt_ff <= pulse_cnt_ff + 5'h01;
          end
        end
        default: state_ff <= wdt_pkg::ST_OFF;
      endcase
    end
  end

  // Action outputs registered from the sequencer state, one cycle behind it
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      COLD_RESET <= 1'b0;
      NMI <= 1'b0;
      WDT_RUNNING <= 1'b0;
    end else begin
      COLD_RESET <= (state_ff == wdt_pkg::ST_FIRE) &&
                    (straps_sync.action == wdt_pkg::ACTION_RESET);
      NMI <= (state_ff == wdt_pkg::ST_FIRE) &&
             (straps_sync.action == wdt_pkg::ACTION_NMI);
      WDT_RUNNING <= (state_ff == wdt_pkg::ST_RUN);
    end
  end

  // Reads of either port return all ones, like an undriven data bus
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IO_RDATA <= 8'h00;
      IO_RDATA_VALID <= 1'b0;
    end else begin
      IO_RDATA_VALID <= rd_enable || rd_disable;
      IO_RDATA <= (rd_enable || rd_disable) ? wdt_pkg::PORT_READ_DATA : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### verif/host_model.sv
/* Host software model issuing I/O port reads.
   Assumes reads are taken on the edge after the strobe is raised. */
`default_nettype none
module host_model (
  // Bus
  input wire logic clk,
  output logic rd,
  output logic [15:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd = 1'b0;
    addr = 16'h0000;
  end
  // One-cycle strobe; address is scrambled once released
  task automatic io_read(input logic [15:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ### verif/wdt_chk_sva.sv
/* Port checker for wdt_top.
   Assumes it is bound to wdt_top. */
`default_nettype none
module wdt_chk (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic IO_RD,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_RDATA_VALID,
  input wire logic COLD_RESET,
  input wire logic NMI,
  input wire logic WDT_RUNNING
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic en_rd;
  logic dis_rd;
  logic fire;
  assign en_rd = IO_RD && IO_ADDR == wdt_pkg::ENABLE_PORT_ADDR;
  assign dis_rd = IO_RD && IO_ADDR == wdt_pkg::DISABLE_PORT_ADDR;
  assign fire = COLD_RESET || NMI;
  sequence s_hi8(sig);
    sig [*8];
  endsequence
  property p_en; en_rd && !fire |-> ##2 (WDT_RUNNING || fire); endproperty
  a_en: assert property (p_en) else $error("enable read did not start");
  property p_rise; $rose(WDT_RUNNING) |-> $past(en_rd, 2); endproperty
  a_rise: assert property (p_rise) else $error("start without enable");
  property p_dis; dis_rd |-> ##2 !WDT_RUNNING; endproperty
  a_dis: assert property (p_dis) else $error("disable read ignored");
  property p_ack;
    (en_rd || dis_rd) && !fire |=> IO_RDATA_VALID && IO_RDATA == wdt_pkg::PORT_READ_DATA;
  endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_cold;
    $rose(COLD_RESET) |-> s_hi8(COLD_RESET) ##1 s_hi8(COLD_RESET) ##1 !COLD_RESET;
  endproperty
  a_cold: assert property (p_cold) else $error("reset pulse width");
  property p_nmi; $rose(NMI) |-> s_hi8(NMI) ##1 s_hi8(NMI) ##1 !NMI; endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt pulse width");
  property p_src; $rose(fire) |-> $past(WDT_RUNNING) && !(COLD_RESET && NMI); endproperty
  a_src: assert property (p_src) else $error("action while stopped");
endmodule
bind wdt_top wdt_chk u_chk (
  .CORE_CLK(CORE_CLK),
  .RST_B(RST_B),
  .IO_RD(IO_RD),
  .IO_ADDR(IO_ADDR),
  .IO_RDATA(IO_RDATA),
  .IO_RDATA_VALID(IO_RDATA_VALID),
  .COLD_RESET(COLD_RESET),
  .NMI(NMI),
  .WDT_RUNNING(WDT_RUNNING)
);
`default_nettype wire

// ### verif/wdt_top_tb.sv
/* Self-checking bench for wdt_top.
   Assumes host_model makes the reads. */
`default_nettype none
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, v); end end
module wdt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic act = 1'b0;
  logic [1:0] per = 2'h0;
  logic rd, vld, cold, nmi, run;
  logic [15:0] addr;
  logic [7:0] rdata;
  int n_mismatch = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  host_model host (.clk(clk), .rd(rd), .addr(addr));
  // Four-cycle tick so every period choice under test expires within the run
  wdt_top #(.CYCLES_PER_TICK(4)) uut (.CORE_CLK(clk), .RST_B(rst_b), .IO_RD(rd),
    .IO_ADDR(addr), .IO_RDATA(rdata),
    .IO_RDATA_VALID(vld), .TIMEOUT_ACTION_STRAP(act), .TIMEOUT_PERIOD_STRAPS(per),
    .COLD_RESET(cold), .NMI(nmi), .WDT_RUNNING(run));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic io_rd(input logic [15:0] a, input logic hit);
    host.io_read(a);
    #1;
    `CHK("valid", hit, vld)
    `CHK("rdata", hit ? wdt_pkg::PORT_READ_DATA : 8'h00, rdata)
  endtask
  task automatic idle(input int n, input logic exp);
    repeat (n) @(posedge clk);
    #1;
    `CHK("running", exp, run)
    `CHK("action", 2'b00, {cold, nmi})
  endtask
  // Waits into the action pulse; the countdown must already have stopped
  task automatic expire(input int n, input logic [1:0] exp);
    repeat (n) @(posedge clk);
    #1;
    `CHK("running", 1'b0, run)
    `CHK("action", exp, {cold, nmi})
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    idle(2, 1'b0);
    io_rd(16'h0044, 1'b0);
    idle(2, 1'b0);
    $display("reset test done");
    // Straps rest at the shortest period, 4000 cycles, with cold reset as action
    io_rd(wdt_pkg::ENABLE_PORT_ADDR, 1'b1);
    idle(1, 1'b1);
    // Gaps stay inside 70 percent of the period; unrefreshed it would fire
    repeat (4) begin
      io_rd(wdt_pkg::ENABLE_PORT_ADDR, 1'b1);
      idle(2500, 1'b1);
    end
    io_rd(wdt_pkg::DISABLE_PORT_ADDR, 1'b1);
    idle(1, 1'b0);
    idle(6000, 1'b0);
    $display("refresh test done");
    // Expiry falls 3997 to 4000 cycles after the load, by tick phase
    io_rd(wdt_pkg::ENABLE_PORT_ADDR, 1'b1);
    idle(3996, 1'b1);
    expire(8, 2'b10);
    idle(20, 1'b0);
    $display("cold reset test done");
    @(posedge clk);
    act <= 1'b1;
    per <= 2'h1;
    idle(3, 1'b0);
    io_rd(wdt_pkg::ENABLE_PORT_ADDR, 1'b1);
    idle(7996, 1'b1);
    expire(8, 2'b01);
    idle(20, 1'b0);
    $display("interrupt test done");
    io_rd(wdt_pkg::ENABLE_PORT_ADDR, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    idle(2, 1'b0);
    idle(9000, 1'b0);
    $display("mid-run reset test done");
    io_rd(wdt_pkg::ENABLE_PORT_ADDR, 1'b1);
    io_rd(wdt_pkg::DISABLE_PORT_ADDR, 1'b1);
    idle(2, 1'b0);
    idle(9000, 1'b0);
    $display("back to back test done");
    stop_test();
  end
  initial begin
    #2800000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
